//--- verilog/tcd_dispatch.v
// Tag command dispatcher: command register, operation launch, completion and key readback
//
// Operation
// - Serial code 0x13 answers ack then the sixteen init vector bytes.
// - Serial code 0x14 answers ack then the key bytes.
// - A command register write while no operation is pending requests the operation with that code.
// - Operation starts only after the host transfer writing it has ended.
// - A finished operation sends an unsolicited completion response.
// - Result register refreshes after every executed operation.
// - Code 0x00 does nothing; 0x01 identifies tag and updates identity registers.
// - Codes 0x02 to 0x05 access blocks; reads also update the buffer.
// - Codes 0x06, 0x07 access pages; read also updates the buffer.
// - Codes 0x08, 0x09 encrypt or decrypt buffer data, updating result and buffer.
// - Codes 0x0a to 0x10 are value block operations with signed values.
// - Code 0x13 configures identifier mode, updating only the result.
// - Codes 0x14 to 0x16 read, increment or tear-check counters.
// - Code 0x17 authenticates by password, updating result and buffer.
// - Code 0x19 computes a CRC, updating result and data buffer.
// - Code 0x1a copies bytes between any module memory addresses.
// - Code 0x1b unlocks by password; 0x1c locks, updating result and nonvolatile.
// - Code 0x22 starts periodic polling, updating the result register.
// - Identify with no tag stores the no-tag code as tag type.
`timescale 1ns/100ps
`include "tcd_regs.vh"

module tcd_dispatch #(
    parameter IV_BYTES = 16,
    parameter KEY_BYTES = 16
) (
    input wire i_clock,                 // Module clock, 50 MHz
    input wire i_nrst,                  // Asynchronous reset, active low
    input wire i_cmd_wr,                // Host write into command register, one-cycle pulse
    input wire [7:0] i_cmd_code,        // Value written into command register
    input wire i_xfer_busy,             // Host transfer still in progress, level
    input wire i_ser_req,               // Serial argument-free command, one-cycle pulse
    input wire [7:0] i_ser_code,        // Serial command code
    input wire [8*IV_BYTES-1:0] i_iv,   // Current init vector, byte 0 low
    input wire [8*KEY_BYTES-1:0] i_key, // Current key, byte 0 low
    input wire i_op_done,               // Tag engine finished operation, pulse
    input wire [7:0] i_op_result,       // Tag engine outcome code
    input wire i_tag_found,             // Identify found a tag
    input wire [7:0] i_tag_type,        // Tag type from engine
    input wire i_tx_ready,              // Serial transmitter accepts a byte
    output reg o_op_start,              // Start tag engine, one-cycle pulse
    output reg [7:0] o_op_code,         // Code of operation being executed
    output reg [3:0] o_op_mem,          // Memory class the operation may modify
    output reg o_op_busy,               // Operation pending or running
    output reg [7:0] o_result,          // Result register
    output reg [7:0] o_tag_type,        // Tag type register
    output reg o_result_wr,             // Result register refreshed, pulse
    output reg o_async_resp,            // Completion response request, pulse
    output wire o_tx_valid,             // Serial byte valid
    output reg [7:0] o_tx_data,         // Serial byte
    output reg o_tx_last                // Last byte of serial answer
);

    localparam ST_IDLE = 2'h0;
    localparam ST_WAIT = 2'h1;
    localparam ST_RUN = 2'h2;

    reg [1:0] state;
    reg [7:0] pend_code;
    reg ser_act;
    reg ser_is_key;
    reg [4:0] ser_idx;
    reg [4:0] ser_len;
    reg [8*IV_BYTES-1:0] iv_snap;
    reg [8*KEY_BYTES-1:0] key_snap;
    wire [4:0] pay_idx;
    reg code_ok;
    reg [3:0] mem_class;

    // Classifies a code: defined or not, and which memory it touches
    always @* begin
        code_ok = 1'b1;
        mem_class = `TCD_MEM_NONE;
        // One entry per defined code; anything above the polling code is undefined
        case (pend_code)
            `TCD_CMD_NONE: begin
                mem_class = `TCD_MEM_NONE;
            end
            `TCD_CMD_GET_UID: begin
                mem_class = `TCD_MEM_UID;
            end
            `TCD_CMD_BLK_FIRST: begin
                mem_class = `TCD_MEM_BUF;
            end
            8'h03: begin
                mem_class = `TCD_MEM_NONE;
            end
            8'h04: begin
                mem_class = `TCD_MEM_BUF;
            end
            `TCD_CMD_BLK_LAST: begin
                mem_class = `TCD_MEM_NONE;
            end
            `TCD_CMD_PAGE_RD: begin
                mem_class = `TCD_MEM_BUF;
            end
            `TCD_CMD_PAGE_WR: begin
                mem_class = `TCD_MEM_NONE;
            end
            `TCD_CMD_ENCRYPT: begin
                mem_class = `TCD_MEM_BUF;
            end
            `TCD_CMD_DECRYPT: begin
                mem_class = `TCD_MEM_BUF;
            end
            `TCD_CMD_VAL_FIRST: begin
                mem_class = `TCD_MEM_BUF;
            end
            8'h0b: begin
                mem_class = `TCD_MEM_NONE;
            end
            8'h0c: begin
                mem_class = `TCD_MEM_NONE;
            end
            8'h0d: begin
                mem_class = `TCD_MEM_NONE;
            end
            8'h0e: begin
                mem_class = `TCD_MEM_NONE;
            end
            8'h0f: begin
                mem_class = `TCD_MEM_NONE;
            end
            `TCD_CMD_VAL_LAST: begin
                mem_class = `TCD_MEM_NONE;
            end
            8'h11: begin
                mem_class = `TCD_MEM_BUF;
            end
            8'h12: begin
                mem_class = `TCD_MEM_BUF;
            end
            `TCD_CMD_CFG_UID: begin
                mem_class = `TCD_MEM_NONE;
            end
            `TCD_CMD_CNT_FIRST: begin
                mem_class = `TCD_MEM_BUF;
            end
            8'h15: begin
                mem_class = `TCD_MEM_NONE;
            end
            `TCD_CMD_CNT_LAST: begin
                mem_class = `TCD_MEM_BUF;
            end
            `TCD_CMD_PWD_AUTH: begin
                mem_class = `TCD_MEM_BUF;
            end
            8'h18: begin
                mem_class = `TCD_MEM_NONE;
            end
            `TCD_CMD_CRC: begin
                mem_class = `TCD_MEM_BUF;
            end
            `TCD_CMD_COPY: begin
                mem_class = `TCD_MEM_ALL;
            end
            `TCD_CMD_UNLOCK: begin
                mem_class = `TCD_MEM_NONE;
            end
            `TCD_CMD_LOCK: begin
                mem_class = `TCD_MEM_NVM;
            end
            8'h1d: begin
                mem_class = `TCD_MEM_BUF;
            end
            8'h1e: begin
                mem_class = `TCD_MEM_ALL;
            end
            8'h1f: begin
                mem_class = `TCD_MEM_BUF;
            end
            8'h20: begin
                mem_class = `TCD_MEM_BUF;
            end
            8'h21: begin
                mem_class = `TCD_MEM_NONE;
            end
            `TCD_CMD_POLL: begin
                mem_class = `TCD_MEM_POLL;
            end
            default: begin
                code_ok = 1'b0;
                mem_class = `TCD_MEM_NONE;
            end
        endcase
    end

    // Operation sequencer
    always @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            state <= ST_IDLE;
            pend_code <= 8'h00;
            o_op_start <= 1'b0;
            o_op_code <= 8'h00;
            o_op_mem <= 4'h0;
            o_op_busy <= 1'b0;
            o_result <= 8'h00;
            o_tag_type <= 8'h00;
            o_result_wr <= 1'b0;
            o_async_resp <= 1'b0;
        end else begin
            o_op_start <= 1'b0;
            o_result_wr <= 1'b0;
            o_async_resp <= 1'b0;
            case (state)
                ST_IDLE: begin
                    // Writes while busy are dropped; the host waits for the response
                    if (i_cmd_wr) begin
                        pend_code <= i_cmd_code;
                        o_op_busy <= 1'b1;
                        state <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (!i_xfer_busy) begin
                        o_op_code <= pend_code;
                        o_op_mem <= mem_class;
                        if (!code_ok) begin
                            o_result <= `TCD_RES_BAD_CMD;
                            o_result_wr <= 1'b1;
                            o_async_resp <= 1'b1;
                            o_op_busy <= 1'b0;
                            state <= ST_IDLE;
                        end else if (pend_code == `TCD_CMD_NONE) begin
                            o_result <= `TCD_RES_OK;
                            o_result_wr <= 1'b1;
                            o_async_resp <= 1'b1;
                            o_op_busy <= 1'b0;
                            state <= ST_IDLE;
                        end else begin
                            o_op_start <= 1'b1;
                            state <= ST_RUN;
                        end
                    end
                end
                ST_RUN: begin
                    if (i_op_done) begin
                        o_result <= i_op_result;
                        o_result_wr <= 1'b1;
                        o_async_resp <= 1'b1;
                        o_op_busy <= 1'b0;
                        // Only the identify operation touches the tag type register
                        if (o_op_code == `TCD_CMD_GET_UID) begin
                            o_tag_type <= i_tag_found ? i_tag_type : `TCD_TYPE_NO_TAG;
                        end
                        state <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    assign o_tx_valid = ser_act;
    assign pay_idx = ser_idx - 5'h01;

    // Serial readback of init vector and key: ack byte, then payload low byte first
    always @* begin
        o_tx_data = `TCD_SER_ACK;
        if (ser_idx != 5'h00) begin
            o_tx_data = ser_is_key ? key_snap[8*pay_idx +: 8] : iv_snap[8*pay_idx +: 8];
        end
        o_tx_last = (ser_idx == ser_len);
    end

    // Snapshot taken at the request so an update mid-answer cannot tear the bytes
    always @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            ser_act <= 1'b0;
            ser_is_key <= 1'b0;
            ser_idx <= 5'h00;
            ser_len <= 5'h00;
            iv_snap <= {8*IV_BYTES{1'b0}};
            key_snap <= {8*KEY_BYTES{1'b0}};
        end else if (!ser_act) begin
            if (i_ser_req && i_ser_code == `TCD_SER_READ_IV) begin
                ser_act <= 1'b1;
                ser_is_key <= 1'b0;
                ser_idx <= 5'h00;
                ser_len <= `TCD_IV_BYTES;
                iv_snap <= i_iv;
            end else if (i_ser_req && i_ser_code == `TCD_SER_READ_KEY) begin
                ser_act <= 1'b1;
                ser_is_key <= 1'b1;
                ser_idx <= 5'h00;
                ser_len <= `TCD_KEY_BYTES;
                key_snap <= i_key;
            end
        end else if (i_tx_ready) begin
            if (o_tx_last) begin
                ser_act <= 1'b0;
            end else begin
                ser_idx <= ser_idx + 5'h01;
            end
        end
    end

endmodule

//--- verilog/tcd_regs.vh
// Command codes, serial command codes, result codes and memory classes for the tag command dispatcher
`ifndef TCD_REGS_VH
`define TCD_REGS_VH
`define TCD_CMD_NONE 8'h00
`define TCD_CMD_GET_UID 8'h01
`define TCD_CMD_BLK_FIRST 8'h02
`define TCD_CMD_BLK_LAST 8'h05
`define TCD_CMD_PAGE_RD 8'h06
`define TCD_CMD_PAGE_WR 8'h07
`define TCD_CMD_ENCRYPT 8'h08
`define TCD_CMD_DECRYPT 8'h09
`define TCD_CMD_VAL_FIRST 8'h0a
`define TCD_CMD_VAL_LAST 8'h10
`define TCD_CMD_CFG_UID 8'h13
`define TCD_CMD_CNT_FIRST 8'h14
`define TCD_CMD_CNT_LAST 8'h16
`define TCD_CMD_PWD_AUTH 8'h17
`define TCD_CMD_CRC 8'h19
`define TCD_CMD_COPY 8'h1a
`define TCD_CMD_UNLOCK 8'h1b
`define TCD_CMD_LOCK 8'h1c
`define TCD_CMD_POLL 8'h22
`define TCD_SER_READ_IV 8'h13
`define TCD_SER_READ_KEY 8'h14
`define TCD_IV_BYTES 5'h10
`define TCD_KEY_BYTES 5'h10
`define TCD_RES_OK 8'h00
`define TCD_RES_BAD_CMD 8'h01
`define TCD_TYPE_NO_TAG 8'h00
`define TCD_SER_ACK 8'h00
`define TCD_MEM_NONE 4'h0
`define TCD_MEM_UID 4'h1
`define TCD_MEM_BUF 4'h2
`define TCD_MEM_NVM 4'h3
`define TCD_MEM_ALL 4'h4
`define TCD_MEM_POLL 4'h5
`endif

//--- verification/tcd_dispatch_sva.sv
// Port assertions for the tag command dispatcher
`timescale 1ns/100ps
module tcd_dispatch_sva #(parameter IV_BYTES = 16, parameter KEY_BYTES = 16) (
    input wire i_clock, i_nrst, i_cmd_wr, i_xfer_busy, i_ser_req, // Control inputs
    input wire [7:0] i_cmd_code, i_ser_code, i_op_result, i_tag_type, // Codes in
    input wire [8*IV_BYTES-1:0] i_iv, // Vector
    input wire [8*KEY_BYTES-1:0] i_key, // Key
    input wire i_op_done, i_tag_found, i_tx_ready, // Engine and transmitter
    input wire o_op_start, o_op_busy, o_result_wr, o_async_resp, // Status out
    input wire [7:0] o_op_code, o_result, o_tag_type, o_tx_data, // Values out
    input wire [3:0] o_op_mem, // Memory class
    input wire o_tx_valid, o_tx_last // Serial out
);
    reg run;
    always @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) run <= 1'b0;
        else if (o_op_start) run <= 1'b1;
        else if (o_async_resp) run <= 1'b0;
    end
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_nrst);
    chk_resp_pair: assert property (o_async_resp == o_result_wr)
        else $error("Response and result pulses differ");
    chk_take_busy: assert property (i_cmd_wr && !o_op_busy |=> o_op_busy)
        else $error("Command write not taken");
    chk_start_after: assert property (o_op_start |-> !$past(i_xfer_busy) && o_op_busy)
        else $error("Start during host transfer");
    chk_start_code: assert property (o_op_start |-> o_op_code != 0 && o_op_code <= 8'h22)
        else $error("Engine started on idle or undefined code");
    chk_done_resp: assert property (run && i_op_done && !o_async_resp |=>
        o_async_resp && !o_op_busy && o_result == $past(i_op_result)) else $error("No completion");
    chk_no_tag: assert property (run && i_op_done && o_op_code == 1 && !i_tag_found |=>
        o_tag_type == 8'h00) else $error("Tag type not cleared");
    chk_ser_go: assert property (i_ser_req && !o_tx_valid && (i_ser_code == 8'h13 ||
        i_ser_code == 8'h14) |=> o_tx_valid && o_tx_data == 8'h00) else $error("No ack");
    chk_tx_hold: assert property (o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_data))
        else $error("Serial byte not held");
    chk_last_end: assert property (o_tx_valid && o_tx_last && i_tx_ready |=> !o_tx_valid)
        else $error("Answer runs past last byte");
    cov_start: cover property (o_op_start);
    cov_bad: cover property (o_async_resp && o_result == 8'h01);
    cov_last: cover property (o_tx_last && i_tx_ready);
endmodule

//--- verification/tcd_engine_model.sv
// Tag engine and serial transmitter model facing the dispatcher
`timescale 1ns/100ps
module tcd_engine_model (
    input wire i_clock, // Clock
    input wire i_nrst, // Reset, active low
    input wire i_op_start, // Start pulse
    input wire [7:0] i_op_code, // Operation code
    input wire [3:0] i_delay, // Engine latency
    output reg o_op_done, // Done pulse
    output wire [7:0] o_op_result, // Outcome
    output reg o_tx_ready // Ready, stalls every other cycle
);
    reg run;
    reg [3:0] cnt;
    // Outcome is only meaningful with done; otherwise show a changing pattern
    assign o_op_result = o_op_done ? i_op_code ^ 8'h5a : {cnt, ~cnt};
    always @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            o_op_done <= 1'b0;
            run <= 1'b0;
            cnt <= 4'h0;
            o_tx_ready <= 1'b0;
        end else begin
            o_tx_ready <= ~o_tx_ready;
            o_op_done <= run && cnt == 4'h0;
            cnt <= i_op_start ? i_delay : cnt - 4'h1;
            run <= i_op_start || (run && cnt != 4'h0);
        end
    end
endmodule

//--- verification/test_tag_command_dispatcher.sv
// Self-checking bench for the tag command dispatcher
`timescale 1ns/100ps
`include "tcd_regs.vh"
module test_tag_command_dispatcher;
    reg i_clock = 0, i_nrst = 0, i_cmd_wr = 0, i_xfer_busy = 0, i_ser_req = 0, i_tag_found = 0;
    reg [7:0] i_cmd_code = 0, i_ser_code = 0, i_tag_type = 8'h3c;
    reg [3:0] dly = 4'h3;
    reg [127:0] i_iv = 128'h0f1e2d3c4b5a69788796a5b4c3d2e1f0;
    reg [127:0] i_key = 128'hfedcba98765432100123456789abcdef;
    wire o_op_start, o_op_busy, o_result_wr, o_async_resp, o_tx_valid, o_tx_last;
    wire i_op_done, i_tx_ready;
    wire [7:0] o_op_code, o_result, o_tag_type, o_tx_data, i_op_result;
    wire [3:0] o_op_mem;
    int n_fail = 0, compares = 0;
    // Upper nibble is the expected memory class, f when not checked
    reg [11:0] rows [0:21] = '{12'hf00, 12'h101, 12'h202, 12'hf03, 12'hf05, 12'h206, 12'hf07,
        12'hf08, 12'hf09, 12'hf0a, 12'hf10, 12'hf11, 12'hf13, 12'hf14, 12'hf16, 12'hf17,
        12'h219, 12'h41a, 12'h31c, 12'h522, 12'hf23, 12'hfff};
    tcd_dispatch DUT (.i_clock(i_clock), .i_nrst(i_nrst), .i_cmd_wr(i_cmd_wr),
        .i_cmd_code(i_cmd_code), .i_xfer_busy(i_xfer_busy), .i_ser_req(i_ser_req),
        .i_ser_code(i_ser_code), .i_iv(i_iv), .i_key(i_key), .i_op_done(i_op_done),
        .i_op_result(i_op_result), .i_tag_found(i_tag_found), .i_tag_type(i_tag_type),
        .i_tx_ready(i_tx_ready), .o_op_start(o_op_start), .o_op_code(o_op_code),
        .o_op_mem(o_op_mem), .o_op_busy(o_op_busy), .o_result(o_result),
        .o_tag_type(o_tag_type), .o_result_wr(o_result_wr), .o_async_resp(o_async_resp),
        .o_tx_valid(o_tx_valid), .o_tx_data(o_tx_data), .o_tx_last(o_tx_last));
    tcd_engine_model ENG (.i_clock(i_clock), .i_nrst(i_nrst), .i_op_start(o_op_start),
        .i_op_code(o_op_code), .i_delay(dly), .o_op_done(i_op_done),
        .o_op_result(i_op_result), .o_tx_ready(i_tx_ready));
    task chk(input [7:0] got, input [7:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Host write with the transfer still running for two more cycles
    task do_cmd(input [7:0] code, input [3:0] mem, output reg st);
        int n;
        n = 0;
        st = 0;
        i_cmd_code = code;
        i_cmd_wr = 1;
        i_xfer_busy = 1;
        @(posedge i_clock) #2 i_cmd_wr = 0;
        repeat (2) @(posedge i_clock);
        #2 i_xfer_busy = 0;
        while (o_async_resp !== 1'b1 && n < 60) begin
            @(posedge i_clock) #2 n++;
            if (o_op_start === 1'b1) begin
                st = 1;
                chk(o_op_code, code);
                if (mem != 4'hf) chk({4'h0, o_op_mem}, {4'h0, mem});
            end
        end
        if (n >= 60) n_fail++;
    endtask
    task ser(input [7:0] code, input [127:0] exp);
        int n, k;
        n = 0;
        k = 0;
        i_ser_code = code;
        i_ser_req = 1;
        @(posedge i_clock) #2 i_ser_req = 0;
        while (k < 17 && n < 100) begin
            @(negedge i_clock) n++;
            if (o_tx_valid === 1'b1 && i_tx_ready === 1'b1) begin
                chk(o_tx_data, k == 0 ? `TCD_SER_ACK : exp[8*(k-1) +: 8]);
                chk(o_tx_last, k == 16);
                k++;
            end
        end
        repeat (2) @(posedge i_clock);
        #2 chk(o_tx_valid, 0);
        $display("Serial code %h done", code);
    endtask
    task final_report;
        $display("Compares %0d, mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        forever #10 i_clock = ~i_clock;
    end
    initial begin
        #200_000;
        n_fail++;
        final_report;
    end
    initial begin
        reg [7:0] c;
        reg e, st;
        repeat (4) @(posedge i_clock);
        #2 i_nrst = 1;
        chk({o_op_busy, o_tx_valid, o_async_resp}, 8'h00);
        for (int i = 0; i < 22; i++) begin
            c = rows[i][7:0];
            e = c != 8'h00 && c <= 8'h22;
            dly = 4'(i % 4 * 3);
            do_cmd(c, rows[i][11:8], st);
            chk(st, e);
            chk(o_result, e ? c ^ 8'h5a : c ? `TCD_RES_BAD_CMD : `TCD_RES_OK);
            chk(o_op_busy, 0);
            $display("Command %h done", c);
        end
        i_tag_found = 1;
        do_cmd(8'h01, 4'h1, st);
        chk(o_tag_type, 8'h3c);
        i_tag_found = 0;
        do_cmd(8'h01, 4'h1, st);
        chk(o_tag_type, `TCD_TYPE_NO_TAG);
        $display("Tag type tests done");
        dly = 4'hc;
        fork
            do_cmd(8'h02, 4'h2, st);
            begin
                repeat (6) @(posedge i_clock);
                #2 i_cmd_code = 8'h1c;
                i_cmd_wr = 1;
                @(posedge i_clock) #2 i_cmd_wr = 0;
            end
        join
        chk(o_result, 8'h02 ^ 8'h5a);
        $display("Write while busy done");
        i_cmd_code = `TCD_CMD_ENCRYPT;
        i_cmd_wr = 1;
        @(posedge i_clock) #2 i_cmd_wr = 0;
        repeat (3) @(posedge i_clock);
        #2 i_nrst = 0;
        @(posedge i_clock) #2 chk({o_op_busy, o_op_start, o_async_resp, o_tx_valid}, 8'h00);
        chk(o_result, `TCD_RES_OK);
        i_nrst = 1;
        do_cmd(`TCD_CMD_GET_UID, `TCD_MEM_UID, st);
        chk(st, 1);
        $display("Reset during operation done");
        ser(`TCD_SER_READ_IV, i_iv);
        ser(`TCD_SER_READ_KEY, i_key);
        final_report;
    end
endmodule
bind tcd_dispatch tcd_dispatch_sva #(.IV_BYTES(IV_BYTES), .KEY_BYTES(KEY_BYTES)) SVA (
    .i_clock(i_clock), .i_nrst(i_nrst), .i_cmd_wr(i_cmd_wr), .i_cmd_code(i_cmd_code),
    .i_xfer_busy(i_xfer_busy), .i_ser_req(i_ser_req), .i_ser_code(i_ser_code), .i_iv(i_iv),
    .i_key(i_key), .i_op_done(i_op_done), .i_op_result(i_op_result), .i_tag_found(i_tag_found),
    .i_tag_type(i_tag_type), .i_tx_ready(i_tx_ready), .o_op_start(o_op_start),
    .o_op_code(o_op_code), .o_op_mem(o_op_mem), .o_op_busy(o_op_busy), .o_result(o_result),
    .o_tag_type(o_tag_type), .o_result_wr(o_result_wr), .o_async_resp(o_async_resp),
    .o_tx_valid(o_tx_valid), .o_tx_data(o_tx_data), .o_tx_last(o_tx_last));
